// ===== rtl/tim_oc_irq.sv
// four-channel 16-bit timer: counter, output compare, flags and interrupt requests
`timescale 1ns/1ns
module tim_oc_irq
(
	// clock and reset
	input  wire logic                                        sys_clk_i,
	input  wire logic                                        rst_b_i,
	// counter control
	input  wire logic                                        timer_enable_i,
	input  wire logic [tim_oc_pkg::PSEL_W-1:0]               prescale_select_i,
	input  wire logic                                        overflow_irq_enable_i,
	input  wire logic                                        overflow_flag_clear_i,
	// channel configuration and compare values
	input  wire tim_oc_pkg::chan_cfg_t [tim_oc_pkg::NUM_CHAN-1:0] chan_cfg_i,
	input  wire logic [tim_oc_pkg::NUM_CHAN-1:0][tim_oc_pkg::CNT_W-1:0] compare_value_i,
	input  wire logic [tim_oc_pkg::NUM_CHAN-1:0]             force_compare_bit_i,
	input  wire logic [tim_oc_pkg::NUM_CHAN-1:0]             chan_flag_clear_i,
	input  wire logic [tim_oc_pkg::NUM_CHAN-1:0]             capture_event_i,
	// channel 3 override and accumulator use of its pin
	input  wire tim_oc_pkg::ch3_ctrl_t                       ch3_ctrl_i,
	input  wire logic                                        pacc_enable_i,
	// general-purpose port bits of the channel pins
	input  wire logic [tim_oc_pkg::NUM_CHAN-1:0]             port_dir_i,
	input  wire logic [tim_oc_pkg::NUM_CHAN-1:0]             port_data_wr_i,
	input  wire logic [tim_oc_pkg::NUM_CHAN-1:0]             port_data_i,
	// counter and status
	output logic [tim_oc_pkg::CNT_W-1:0]                     counter_o,
	output logic [tim_oc_pkg::NUM_CHAN-1:0]                  chan_event_flag_o,
	output logic                                             overflow_flag_o,
	// interrupt requests
	output logic [tim_oc_pkg::NUM_CHAN-1:0]                  chan_irq_o,
	output logic                                             overflow_irq_o,
	// channel pins
	output logic [tim_oc_pkg::NUM_CHAN-1:0]                  chan_pin_o,
	output logic [tim_oc_pkg::NUM_CHAN-1:0]                  chan_pin_oe_o
);
	import tim_oc_pkg::*;

	logic                rst_b;
	logic [PRESC_W-1:0]  presc_q;
	logic [PRESC_W-1:0]  presc_d;
	logic [PRESC_W:0]    div_full;
	logic [PRESC_W-1:0]  div_mask;
	logic                tick;
	logic [CNT_W-1:0]    cnt_q;
	logic [CNT_W-1:0]    cnt_d;
	logic                wrap;
	logic                ch3_reset;
	logic [NUM_CHAN-1:0] dir;
	logic [NUM_CHAN-1:0] match;
	logic [NUM_CHAN-1:0] forced;
	logic [NUM_CHAN-1:0] oc_event;
	logic                ch3_event;
	logic [NUM_CHAN-1:0] override;
	logic [NUM_CHAN-1:0] oc_level;
	logic [NUM_CHAN-1:0] oc_ctrl;
	logic [NUM_CHAN-1:0] flag_set;
	logic [NUM_CHAN-1:0] flag_q;
	logic [NUM_CHAN-1:0] flag_d;
	logic                ovf_q;
	logic                ovf_d;
	logic [NUM_CHAN-1:0] latch_q;
	logic [NUM_CHAN-1:0] latch_d;
	logic [NUM_CHAN-1:0] pin_q;
	logic [NUM_CHAN-1:0] pin_d;
	logic [NUM_CHAN-1:0] oe_q;
	logic [NUM_CHAN-1:0] oe_d;

	rst_sync u_rst_sync
	(
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.rst_b_o   (rst_b)
	);

	// prescaler: tick when the low sel bits of the free count are all ones
	assign div_full = DIV_ONE << prescale_select_i;
	assign div_mask = div_full[PRESC_W-1:0] - PRESC_STEP;
	assign tick     = timer_enable_i && ((presc_q & div_mask) == div_mask);
	assign presc_d  = timer_enable_i ? presc_q + PRESC_STEP : presc_q;

	// counter: wrap and channel 3 reset both land on zero
	assign wrap      = tick && (cnt_q == CNT_MAX);
	assign ch3_reset = match[CH3] && ch3_ctrl_i.ch3_counter_reset_enable;
	assign cnt_d     = !tick    ? cnt_q :
	                   ch3_reset ? CNT_RESET : cnt_q + CNT_STEP;

	always_ff @(posedge sys_clk_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			presc_q <= PRESC_RESET;
			cnt_q   <= CNT_RESET;
		end
		else
		begin
			presc_q <= presc_d;
			cnt_q   <= cnt_d;
		end
	end

	// compare decode; a match is judged once per counter value, on its tick
	genvar g;
	generate
		for (g = 0; g < NUM_CHAN; g++)
		begin : g_chan
			assign dir[g]      = chan_cfg_i[g].chan_dir_select;
			assign match[g]    = tick && dir[g] && (cnt_q == compare_value_i[g]);
			assign forced[g]   = dir[g] && force_compare_bit_i[g];
			assign oc_event[g] = match[g] || forced[g];
			assign override[g] = ch3_event && dir[g] && ch3_ctrl_i.mask[g];

			oc_channel u_oc_channel
			(
				.sys_clk_i       (sys_clk_i),
				.rst_b_i         (rst_b),
				.compare_event_i (oc_event[g]),
				.action_i        ({chan_cfg_i[g].compare_mode_bit,
				                   chan_cfg_i[g].compare_level_bit}),
				.override_i      (override[g]),
				.override_data_i (ch3_ctrl_i.data[g]),
				.level_o         (oc_level[g])
			);
		end
	endgenerate

	// a forced channel 3 compare also overrides, like a real one
	assign ch3_event = oc_event[CH3];

	// channel flags: only real matches or captures set them, never a force; a wrap sets the overflow flag
	assign flag_set = (match & dir) | (capture_event_i & ~dir);
	// set beats a clear arriving in the same cycle
	assign flag_d   = (flag_q & ~chan_flag_clear_i) | flag_set;
	assign ovf_d    = (ovf_q & ~overflow_flag_clear_i) | wrap;

	always_ff @(posedge sys_clk_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			flag_q <= FLAG_RESET;
			ovf_q  <= OVF_RESET;
		end
		else
		begin
			flag_q <= flag_d;
			ovf_q  <= ovf_d;
		end
	end

	// pin ownership: compare logic when connected or masked by channel 3
	generate
		for (g = 0; g < NUM_CHAN; g++)
		begin : g_pin
			if (g == CH3)
			begin : g_acc
				// an accumulator input must never be driven by compare logic
				assign oc_ctrl[g] = dir[g] && !pacc_enable_i &&
				                    (chan_cfg_i[g].compare_mode_bit ||
				                     chan_cfg_i[g].compare_level_bit ||
				                     ch3_ctrl_i.mask[g]);
			end
			else
			begin : g_std
				assign oc_ctrl[g] = dir[g] &&
				                    (chan_cfg_i[g].compare_mode_bit ||
				                     chan_cfg_i[g].compare_level_bit ||
				                     ch3_ctrl_i.mask[g]);
			end
		end
	endgenerate

	// port latch always stores; it only reaches the pin when compare lets go
	assign latch_d = (latch_q & ~port_data_wr_i) | (port_data_i & port_data_wr_i);
	assign pin_d   = (oc_ctrl & oc_level) | (~oc_ctrl & latch_q);
	assign oe_d    = oc_ctrl | port_dir_i;

	always_ff @(posedge sys_clk_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			latch_q <= LATCH_RESET;
			pin_q   <= PIN_VEC_RST;
			oe_q    <= PIN_VEC_RST;
		end
		else
		begin
			latch_q <= latch_d;
			pin_q   <= pin_d;
			oe_q    <= oe_d;
		end
	end

	// outputs; five request lines in all
	assign counter_o         = cnt_q;
	assign chan_event_flag_o = flag_q;
	assign overflow_flag_o   = ovf_q;
	assign chan_irq_o        = flag_q & {chan_cfg_i[3].chan_irq_enable,
	                                     chan_cfg_i[2].chan_irq_enable,
	                                     chan_cfg_i[1].chan_irq_enable,
	                                     chan_cfg_i[0].chan_irq_enable};
	assign overflow_irq_o    = ovf_q && overflow_irq_enable_i;
	assign chan_pin_o        = pin_q;
	assign chan_pin_oe_o     = oe_q;

	// checks
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_b);

	sequence seq_wrap;
		tick && (cnt_q == CNT_MAX);
	endsequence

	sequence seq_zero_flagged;
		(cnt_q == CNT_RESET) && ovf_q;
	endsequence

	sequence seq_div2_run;
		tick ##1 !tick ##1 tick;
	endsequence

	chk_wrap_sets_ovf: assert property (seq_wrap |=> seq_zero_flagged)
		else $error("counter wrap did not zero counter and set overflow flag");

	chk_ovf_request: assert property
		(seq_wrap ##1 overflow_irq_enable_i |-> overflow_irq_o)
		else $error("overflow request missing after wrap with enable set");

	chk_ovf_masked: assert property (!overflow_irq_enable_i |-> !overflow_irq_o)
		else $error("overflow request raised while its enable is clear");

	chk_ch3_cnt_reset: assert property
		((match[CH3] && ch3_ctrl_i.ch3_counter_reset_enable && pacc_enable_i)
		 |=> (cnt_q == CNT_RESET))
		else $error("channel 3 compare did not reset counter in accumulator use");

	chk_ch3_reset_any: assert property
		((match[CH3] && ch3_ctrl_i.ch3_counter_reset_enable) |=> (cnt_q == CNT_RESET))
		else $error("channel 3 compare did not reset counter");

	chk_div2_period: assert property
		((tick && (prescale_select_i == 3'h1)) ##1 (timer_enable_i && (prescale_select_i == 3'h1))
		 |-> !tick)
		else $error("prescaler tick spacing wrong");

	chk_div_spacing: assert property
		((tick && timer_enable_i && $stable(prescale_select_i) && (prescale_select_i == 3'h2))
		 ##1 (timer_enable_i && (prescale_select_i == 3'h2)) [*4]
		 |-> !$past(tick, 1) && !$past(tick, 2) && !$past(tick, 3) && tick)
		else $error("divide-by-4 tick not four cycles apart");

	generate
		for (g = 0; g < NUM_CHAN; g++)
		begin : g_chk
			chk_match_flag: assert property (match[g] |=> flag_q[g])
				else $error("compare match did not set event flag");

			chk_force_noflag: assert property
				((forced[g] && !match[g] && !flag_q[g] && !capture_event_i[g])
				 |=> !flag_q[g])
				else $error("forced compare changed the event flag");

			chk_flag_irq: assert property
				((flag_set[g] && chan_cfg_i[g].chan_irq_enable)
				 ##1 chan_cfg_i[g].chan_irq_enable |-> chan_irq_o[g])
				else $error("channel request missing after event with enable set");

			chk_toggle_act: assert property
				((oc_event[g] && !override[g] && chan_cfg_i[g].compare_mode_bit == 1'b0
				  && chan_cfg_i[g].compare_level_bit == 1'b1)
				 |=> (oc_level[g] != $past(oc_level[g])))
				else $error("toggle action did not invert the compare level");

			chk_ch3_override: assert property
				(override[g] |=> (oc_level[g] == $past(ch3_ctrl_i.data[g])))
				else $error("channel 3 data did not override the compare level");

			chk_port_blocked: assert property
				((oc_ctrl[g] && port_data_wr_i[g]) |=> (chan_pin_o[g] == $past(oc_level[g])))
				else $error("port write disturbed a pin under compare control");

			chk_disconnect: assert property
				((!chan_cfg_i[g].compare_mode_bit && !chan_cfg_i[g].compare_level_bit
				  && !ch3_ctrl_i.mask[g] && !port_dir_i[g]) |=> !chan_pin_oe_o[g])
				else $error("disconnected pin still driven");

			chk_latch_shows: assert property
				((!oc_ctrl[g] && port_dir_i[g]) ##1 (!oc_ctrl[g] && port_dir_i[g])
				 |=> (chan_pin_o[g] == $past(latch_q[g])))
				else $error("latched port value not shown on general-purpose pin");
		end
	endgenerate

endmodule : tim_oc_irq

// ===== include/tim_oc_pkg.sv
// shared constants and carrier types of the timer output-compare and interrupt block
package tim_oc_pkg;

	// channel count and widths
	localparam int NUM_CHAN = 4;
	localparam int CNT_W    = 16;
	localparam int PRESC_W  = 7;
	localparam int PSEL_W   = 3;
	localparam int CH3      = 3;

	// counter values
	localparam logic [CNT_W-1:0]   CNT_RESET   = 16'h0000;
	localparam logic [CNT_W-1:0]   CNT_MAX     = 16'hffff;
	localparam logic [CNT_W-1:0]   CNT_STEP    = 16'h0001;
	localparam logic [PRESC_W-1:0] PRESC_RESET = 7'h00;
	localparam logic [PRESC_W-1:0] PRESC_STEP  = 7'h01;
	localparam logic [PRESC_W:0]   DIV_ONE     = 8'h01;

	// compare action encoding of the {mode, level} pair
	localparam logic [1:0] ACT_NONE   = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR  = 2'h2;
	localparam logic [1:0] ACT_SET    = 2'h3;

	// reset values
	localparam logic                PIN_RESET   = 1'b0;
	localparam logic [NUM_CHAN-1:0] LATCH_RESET = 4'h0;
	localparam logic [NUM_CHAN-1:0] FLAG_RESET  = 4'h0;
	localparam logic [NUM_CHAN-1:0] PIN_VEC_RST = 4'h0;
	localparam logic                OVF_RESET   = 1'b0;

	// per-channel configuration bits
	typedef struct packed {
		logic chan_dir_select;
		logic compare_mode_bit;
		logic compare_level_bit;
		logic chan_irq_enable;
	} chan_cfg_t;

	// channel 3 override and counter-reset controls
	typedef struct packed {
		logic [NUM_CHAN-1:0] mask;
		logic [NUM_CHAN-1:0] data;
		logic                ch3_counter_reset_enable;
	} ch3_ctrl_t;

endpackage : tim_oc_pkg

// ===== rtl/rst_sync.sv
// two-flop release synchroniser for the asynchronous active-low reset
`timescale 1ns/1ns
module rst_sync
(
	// clock and raw reset
	input  wire logic sys_clk_i,
	input  wire logic rst_b_i,
	// synchronised reset
	output logic      rst_b_o
);
	import tim_oc_pkg::*;

	logic meta_q;
	logic hold_q;

	// assertion is immediate, release waits two edges
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			meta_q <= 1'b0;
			hold_q <= 1'b0;
		end
		else
		begin
			meta_q <= 1'b1;
			hold_q <= meta_q;
		end
	end

	assign rst_b_o = hold_q;

endmodule : rst_sync

// ===== rtl/oc_channel.sv
// output-compare level generator of one timer channel
`timescale 1ns/1ns
module oc_channel
(
	// clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rst_b_i,
	// compare trigger and action
	input  wire logic       compare_event_i,
	input  wire logic [1:0] action_i,
	// channel 3 override
	input  wire logic       override_i,
	input  wire logic       override_data_i,
	// resulting output-compare level
	output logic            level_o
);
	import tim_oc_pkg::*;

	logic level_q;
	logic level_d;
	logic action_level;

	// set, clear or toggle; 00 leaves the level alone
	assign action_level = (action_i == ACT_TOGGLE) ? ~level_q :
	                      (action_i == ACT_CLEAR)  ? 1'b0 :
	                      (action_i == ACT_SET)    ? 1'b1 : level_q;

	// channel 3 data wins over the channel's own action
	assign level_d = override_i      ? override_data_i :
	                 compare_event_i ? action_level : level_q;

	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			level_q <= PIN_RESET;
		else
			level_q <= level_d;
	end

	assign level_o = level_q;

endmodule : oc_channel

// ===== test/pin_load.sv
// load model of the four channel pads seen from the board side
`timescale 1ns/1ns
module pin_load
(
	// clock
	input  wire logic       sys_clk_i,
	// pins from the timer
	input  wire logic [3:0] pin_i,
	input  wire logic [3:0] oe_i,
	// level seen on the pads
	output logic      [3:0] pad_o
);
	logic [3:0] last_q = 4'h0;

	// no pull on these pads: a released pad drifts off its last driven level
	assign pad_o = (oe_i & pin_i) | (~oe_i & ~last_q);

	always_ff @(posedge sys_clk_i)
	begin
		last_q <= (oe_i & pin_i) | (~oe_i & last_q);
	end
endmodule : pin_load

// ===== test/tim_oc_irq_test.sv
// self-checking bench of the timer output-compare and interrupt block
`timescale 1ns/1ns
module tim_oc_irq_test;
	import tim_oc_pkg::*;
	logic                                    sys_clk_i = 1'b0;
	logic                                    rst_b_i   = 1'b0;
	logic                                    timer_enable_i, overflow_irq_enable_i;
	logic                                    overflow_flag_clear_i, pacc_enable_i;
	logic [PSEL_W-1:0]                       prescale_select_i;
	chan_cfg_t [NUM_CHAN-1:0]                chan_cfg_i;
	logic [NUM_CHAN-1:0][CNT_W-1:0]          compare_value_i;
	logic [NUM_CHAN-1:0]                     force_compare_bit_i, chan_flag_clear_i;
	logic [NUM_CHAN-1:0]                     capture_event_i, port_dir_i;
	logic [NUM_CHAN-1:0]                     port_data_wr_i, port_data_i;
	ch3_ctrl_t                               ch3_ctrl_i;
	logic [CNT_W-1:0]                        counter_o, c0;
	logic [NUM_CHAN-1:0]                     chan_event_flag_o, chan_irq_o;
	logic [NUM_CHAN-1:0]                     chan_pin_o, chan_pin_oe_o, pad;
	logic                                    overflow_flag_o, overflow_irq_o;
	logic [1:0]                              acts [4] = '{ACT_SET, ACT_CLEAR, ACT_TOGGLE, ACT_TOGGLE};
	int                                      num_errors = 0;
	int                                      num_checks = 0;
	int                                      cycles     = 0;

	tim_oc_irq tim_oc_irq_i (.sys_clk_i, .rst_b_i, .timer_enable_i, .prescale_select_i,
		.overflow_irq_enable_i, .overflow_flag_clear_i, .chan_cfg_i, .compare_value_i,
		.force_compare_bit_i, .chan_flag_clear_i, .capture_event_i, .ch3_ctrl_i,
		.pacc_enable_i, .port_dir_i, .port_data_wr_i, .port_data_i, .counter_o,
		.chan_event_flag_o, .overflow_flag_o, .chan_irq_o, .overflow_irq_o, .chan_pin_o,
		.chan_pin_oe_o);

	pin_load pin_load_i (.sys_clk_i(sys_clk_i), .pin_i(chan_pin_o), .oe_i(chan_pin_oe_o),
		.pad_o(pad));

	always #5 sys_clk_i = ~sys_clk_i;

	// one wrap of the counter plus the short tests stays well below this
	always @(posedge sys_clk_i)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			num_errors++;
			summarize();
		end
	end

	task automatic summarize();
		if (num_errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// edges then settle time, so sampling never races the edge
	task automatic tk(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask : tk

	task automatic set_ch(input int ch, input logic [1:0] a, input logic ie);
		@(posedge sys_clk_i);
		chan_cfg_i[ch] <= '{1'b1, a[1], a[0], ie};
	endtask : set_ch

	// margin of eight counts hides whether the counter read is pre- or post-edge
	task automatic match(input int ch);
		int k;
		@(posedge sys_clk_i);
		compare_value_i[ch] <= counter_o + 16'h0008;
		tk(1);
		for (k = 0; k < 40 && chan_event_flag_o[ch] !== 1'b1; k++)
			tk(1);
	endtask : match

	// sel: 0 flag clear, 1 force, 2 capture, 3 port write; one strobe at a time
	task automatic pulse(input int sel, input int ch);
		@(posedge sys_clk_i);
		case (sel)
			0: chan_flag_clear_i[ch] <= 1'b1;
			1: force_compare_bit_i[ch] <= 1'b1;
			2: capture_event_i[ch] <= 1'b1;
			default: port_data_wr_i[ch] <= 1'b1;
		endcase
		@(posedge sys_clk_i);
		chan_flag_clear_i   <= 4'h0;
		force_compare_bit_i <= 4'h0;
		capture_event_i     <= 4'h0;
		port_data_wr_i      <= 4'h0;
	endtask : pulse

	initial
	begin
		{timer_enable_i, overflow_irq_enable_i, overflow_flag_clear_i, pacc_enable_i} = 4'h0;
		prescale_select_i = 3'h0;
		chan_cfg_i = '0;
		compare_value_i = {4{16'hf000}};
		{force_compare_bit_i, chan_flag_clear_i, capture_event_i} = 12'h000;
		{port_dir_i, port_data_wr_i, port_data_i} = 12'h000;
		ch3_ctrl_i = '0;
		tk(8);
		chk({chan_irq_o, chan_pin_oe_o, counter_o[7:0]}, 16'h0000);
		@(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		timer_enable_i <= 1'b1;
		for (int s = 0; s < 8; s++)
		begin
			@(posedge sys_clk_i);
			prescale_select_i <= 3'(s);
			tk(2);
			c0 = counter_o;
			tk(4 << s);
			chk(counter_o - c0, 16'h0004);
		end
		@(posedge sys_clk_i);
		prescale_select_i <= 3'h0;
		for (int i = 0; i < 4; i++)
		begin
			set_ch(0, acts[i], i != 0);
			match(0);
			chk(chan_event_flag_o[0], 1'b1);
			chk(chan_irq_o[0], i != 0);
			tk(1);
			chk({chan_pin_oe_o[0], pad[0]}, {1'b1, ~i[0]});
			pulse(0, 0);
		end
		set_ch(1, ACT_SET, 1'b1);
		pulse(1, 1);
		tk(1);
		chk({chan_event_flag_o[1], chan_irq_o[1], pad[1]}, 16'h0001);
		@(posedge sys_clk_i);
		port_data_i <= 4'h0;
		pulse(3, 1);
		tk(2);
		chk(pad[1], 1'b1);
		set_ch(1, ACT_NONE, 1'b0);
		port_dir_i[1] <= 1'b1;
		tk(3);
		chk({chan_pin_oe_o[1], pad[1]}, 16'h0002);
		@(posedge sys_clk_i);
		port_dir_i[1] <= 1'b0;
		tk(3);
		chk(chan_pin_oe_o[1], 1'b0);
		@(posedge sys_clk_i);
		chan_cfg_i[2] <= '{1'b0, 1'b0, 1'b0, 1'b1};
		pulse(2, 2);
		tk(1);
		chk({chan_event_flag_o[2], chan_irq_o[2]}, 16'h0003);
		pulse(0, 2);
		set_ch(0, ACT_CLEAR, 1'b0);
		set_ch(1, ACT_SET, 1'b0);
		pulse(1, 0);
		pulse(1, 1);
		@(posedge sys_clk_i);
		ch3_ctrl_i <= '{4'b0011, 4'b0001, 1'b1};
		pacc_enable_i <= 1'b1;
		set_ch(3, ACT_SET, 1'b1);
		tk(2);
		chk(pad[1:0], 16'h0002);
		match(3);
		chk(chan_irq_o[3], 1'b1);
		chk(counter_o, 16'h0000);
		tk(1);
		chk(pad[1:0], 16'h0001);
		@(posedge sys_clk_i);
		chan_cfg_i <= '0;
		ch3_ctrl_i <= '0;
		pacc_enable_i <= 1'b0;
		tk(1);
		for (int k = 0; k < 70000 && overflow_flag_o !== 1'b1; k++)
			tk(1);
		chk({overflow_flag_o, overflow_irq_o}, 16'h0002);
		@(posedge sys_clk_i);
		overflow_irq_enable_i <= 1'b1;
		tk(1);
		chk(overflow_irq_o, 1'b1);
		@(posedge sys_clk_i);
		overflow_flag_clear_i <= 1'b1;
		@(posedge sys_clk_i);
		overflow_flag_clear_i <= 1'b0;
		tk(1);
		chk({overflow_flag_o, overflow_irq_o}, 16'h0000);
		summarize();
	end
endmodule : tim_oc_irq_test
